// ===== src/pbc_pkg.sv
// Package for the per-generator blanking, chop and capture block.
// Assumes a single 100 MHz clock domain shared with the PWM generators.
package pbc_pkg;

	// ========================================================================
	// Register map (16-bit registers, one per even byte address)
	localparam logic [3:0]  OFF_CTRL = 4'h0;
	localparam logic [3:0]  OFF_DLY  = 4'h2;
	localparam logic [3:0]  OFF_AUX  = 4'h4;
	localparam logic [3:0]  OFF_CAP  = 4'h6;

	// Writable bits; everything else reads as zero.
	localparam logic [15:0] CTRL_WMASK = 16'hfc3f;
	localparam logic [15:0] AUX_WMASK  = 16'hcf3f;
	localparam logic [15:0] REG_RESET  = 16'h0000;

	// Field positions of the delay and capture registers.
	localparam int DLY_LSB = 3;
	localparam int DLY_MSB = 11;
	localparam int CAP_LSB = 3;
	localparam int CAP_MSB = 15;

	// ========================================================================
	// Source select codes (shared by state-blank and chop source fields)
	localparam logic [3:0]  SRC_NONE = 4'h0;
	localparam int          NUM_GEN  = 5;

	// ========================================================================
	// Timing: one blanking step in ns and the clock in MHz, both converted to picoseconds.
	localparam real         BLANK_STEP_NS  = 8.32;
	localparam real         CLK_MHZ        = 100.0;
	localparam int          BLANK_STEP_PS  = $rtoi(BLANK_STEP_NS * 1000.0 + 0.5);
	localparam int          CLK_PERIOD_PS  = $rtoi(1000000.0 / CLK_MHZ + 0.5);
	localparam logic [22:0] STEP_PS_W      = 23'(BLANK_STEP_PS);
	localparam logic [22:0] CLK_PS_W       = 23'(CLK_PERIOD_PS);

	// ========================================================================
	// Types
	typedef struct packed {
		logic       trig_high_rising;
		logic       trig_high_falling;
		logic       trig_low_rising;
		logic       trig_low_falling;
		logic       fault_edge_blank_enable;
		logic       curlim_edge_blank_enable;
		logic [3:0] rsvd;
		logic       blank_when_source_high;
		logic       blank_when_source_low;
		logic       blank_on_high_out_high;
		logic       blank_on_high_out_low;
		logic       blank_on_low_out_high;
		logic       blank_on_low_out_low;
	} pbc_ctrl_t;

	typedef struct packed {
		logic       fine_period_disable;
		logic       fine_duty_disable;
		logic [1:0] rsvd_hi;
		logic [3:0] state_blank_source;
		logic [1:0] rsvd_lo;
		logic [3:0] chop_source;
		logic       chop_high_enable;
		logic       chop_low_enable;
	} pbc_aux_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} pbc_bus_req_t;

	typedef struct packed {
		pbc_ctrl_t   ctrl;
		logic [8:0]  dly;
		pbc_aux_t    aux;
		logic [12:0] cap;
		logic [22:0] leb_ps;
		logic        leb_run;
		logic        high_out;
		logic        low_out;
		logic        fault_out;
		logic        curlim_out;
		logic [15:0] rd_data;
	} pbc_state_t;

endpackage

// ===== src/pbc_blank_chop.sv
// One PWM generator's blanking, output chop and time base capture logic.
// Assumes all inputs are synchronous to clock and the fault and
// current-limit inputs arrive already selected and polarity corrected.
//
// Contract
// - Blank inputs while low output high
// - Blank inputs while low output low
// - Nine-bit delay, 8.32 ns per count
// - Period fine-resolution disable bit
// - Duty fine-resolution disable bit
// - Selected state-blank source blocks enabled inputs
// - Blank source: none, generators 1-5, reserved
// - Chop source: chop clock, generators 1-5
// - Chop high output when enabled
// - Chop low output when enabled
// - Current-limit leading edge latches time base
// - Capture only for primary high output
// - Capture follows blanked current-limit signal
// - Capture resolution no finer than 8.32 ns
// - Capture only when external reset clear
// - Unimplemented register bits read zero
// - Four edge enables start blanking counter
// - Separate edge blank enables fault, limit
// - Blank while source high or low
// - Blank while high output high or low
`timescale 1ns/1ps

module pbc_blank_chop (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	// Register port
	input  wire pbc_pkg::pbc_bus_req_t bus_req,
	output      logic [15:0]           bus_rd_data,
	// Generator side
	input  wire logic                  gen_high_in,
	input  wire logic                  gen_low_in,
	input  wire logic [4:0]            peer_high,
	input  wire logic                  chop_clock,
	input  wire logic [12:0]           timebase,
	input  wire logic                  external_period_reset_sel,
	// Protection inputs
	input  wire logic                  fault_in,
	input  wire logic                  curlim_in,
	// Outputs to the power stage and fault logic
	output      logic                  gen_high_output,
	output      logic                  gen_low_output,
	output      logic                  fault_blanked,
	output      logic                  curlim_blanked,
	output      logic                  fine_period_disable,
	output      logic                  fine_duty_disable
);
	import pbc_pkg::*;

	pbc_state_t        st_q;
	pbc_state_t        st_d;
	logic [NUM_GEN-1:0] blank_hit;
	logic [NUM_GEN-1:0] chop_hit;
	logic              blank_src;
	logic              chop_src;
	logic              trig;
	logic [22:0]       leb_target;
	logic [22:0]       leb_next_ps;
	logic              state_blank;
	logic              cap_event;

	// ========================================================================
	// Source selection
	// Reserved codes match no generator, so the source reads low (only source-low blanking applies) and a
	// chopped output stays low; that is the safe side for a power stage.
	genvar g;
	generate
		for (g = 0; g < NUM_GEN; g++) begin : g_src
			assign blank_hit[g] = peer_high[g] &&
				(st_q.aux.state_blank_source == 4'(g + 1));
			assign chop_hit[g]  = peer_high[g] &&
				(st_q.aux.chop_source == 4'(g + 1));
		end
	endgenerate

	assign blank_src = |blank_hit;
	assign chop_src  = (st_q.aux.chop_source == SRC_NONE) ? chop_clock
		: |chop_hit;

	assign leb_target  = 23'(st_q.dly) * STEP_PS_W;
	assign leb_next_ps = st_q.leb_ps + CLK_PS_W;

	// ========================================================================
	// Next state
	always_comb begin
		st_d        = st_q;
		trig        = 1'b0;
		state_blank = 1'b0;
		cap_event   = 1'b0;

		// Register writes; unimplemented bits are never stored.
		if (bus_req.wr) begin
			if (bus_req.addr == OFF_CTRL) begin
				st_d.ctrl = pbc_ctrl_t'(bus_req.wdata & CTRL_WMASK);
			end else if (bus_req.addr == OFF_DLY) begin
				st_d.dly = bus_req.wdata[DLY_MSB:DLY_LSB];
			end else if (bus_req.addr == OFF_AUX) begin
				st_d.aux = pbc_aux_t'(bus_req.wdata & AUX_WMASK);
			end
		end

		// Read data stand for one cycle only; unmapped addresses read zero.
		st_d.rd_data = 16'h0000;
		if (bus_req.rd) begin
			if (bus_req.addr == OFF_CTRL) begin
				st_d.rd_data = 16'(st_q.ctrl);
			end else if (bus_req.addr == OFF_DLY) begin
				st_d.rd_data = {4'h0, st_q.dly, 3'h0};
			end else if (bus_req.addr == OFF_AUX) begin
				st_d.rd_data = 16'(st_q.aux);
			end else if (bus_req.addr == OFF_CAP) begin
				st_d.rd_data = {st_q.cap, 3'h0};
			end
		end

		// Output chopping gates the generator's own level with the source.
		st_d.high_out = gen_high_in &&
			(!st_q.aux.chop_high_enable || chop_src);
		st_d.low_out  = gen_low_in &&
			(!st_q.aux.chop_low_enable || chop_src);

		// Edges are taken on the pins as they are driven, after chopping.
		trig = (st_q.ctrl.trig_high_rising  &&  st_d.high_out && !st_q.high_out)
		    || (st_q.ctrl.trig_high_falling && !st_d.high_out &&  st_q.high_out)
		    || (st_q.ctrl.trig_low_rising   &&  st_d.low_out  && !st_q.low_out)
		    || (st_q.ctrl.trig_low_falling  && !st_d.low_out  &&  st_q.low_out);

		// Leading-edge counter works in picoseconds so that 8.32 ns steps
		// map onto 10 ns cycles without a divider; it rounds up.
		if (trig) begin
			st_d.leb_run = (st_q.dly != 9'h000);
			st_d.leb_ps  = 23'h000000;
		end else if (st_q.leb_run) begin
			if (leb_next_ps >= leb_target) begin
				st_d.leb_run = 1'b0;
				st_d.leb_ps  = 23'h000000;
			end else begin
				st_d.leb_ps = leb_next_ps;
			end
		end

		// State blanking from the generator's own pins and the source.
		state_blank =
			(st_q.ctrl.blank_on_low_out_high  &&  st_d.low_out)  ||
			(st_q.ctrl.blank_on_low_out_low   && !st_d.low_out)  ||
			(st_q.ctrl.blank_on_high_out_high &&  st_d.high_out) ||
			(st_q.ctrl.blank_on_high_out_low  && !st_d.high_out) ||
			(st_q.ctrl.blank_when_source_high &&  blank_src &&
			 st_q.aux.state_blank_source != SRC_NONE) ||
			(st_q.ctrl.blank_when_source_low  && !blank_src &&
			 st_q.aux.state_blank_source != SRC_NONE);

		st_d.fault_out  = fault_in && !state_blank &&
			!(st_d.leb_run && st_q.ctrl.fault_edge_blank_enable);
		st_d.curlim_out = curlim_in && !state_blank &&
			!(st_d.leb_run && st_q.ctrl.curlim_edge_blank_enable);

		// Capture looks at the blanked limit signal, never the raw one, and
		// latches the primary time base; the clock step is coarser than
		// the blanking step, so resolution never goes below 8.32 ns.
		cap_event = st_d.curlim_out && !st_q.curlim_out &&
			!external_period_reset_sel;
		if (cap_event) begin
			st_d.cap = timebase;
		end
	end

	// ========================================================================
	// State register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ========================================================================
	// Outputs
	assign bus_rd_data         = st_q.rd_data;
	assign gen_high_output     = st_q.high_out;
	assign gen_low_output      = st_q.low_out;
	assign fault_blanked       = st_q.fault_out;
	assign curlim_blanked      = st_q.curlim_out;
	assign fine_period_disable = st_q.aux.fine_period_disable;
	assign fine_duty_disable   = st_q.aux.fine_duty_disable;

	// ========================================================================
	// Assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_leb_start;
		trig && st_q.dly != 9'h000;
	endsequence

	sequence s_leb_armed;
		st_q.leb_run && st_q.leb_ps == 23'h000000;
	endsequence

	property p_leb_start;
		s_leb_start |=> s_leb_armed;
	endproperty
	a_leb_start: assert property (p_leb_start)
		else $error("blank counter did not start on enabled edge");

	property p_leb_zero;
		trig && st_q.dly == 9'h000 |=> !st_q.leb_run;
	endproperty
	a_leb_zero: assert property (p_leb_zero)
		else $error("zero delay still produced edge blanking");

	property p_leb_end;
		st_q.leb_run && !trig && leb_next_ps >= leb_target |=> !st_q.leb_run;
	endproperty
	a_leb_end: assert property (p_leb_end)
		else $error("blank counter ran past programmed delay");

	property p_leb_hold;
		st_q.leb_run && !trig && leb_next_ps < leb_target
			|=> st_q.leb_run && st_q.leb_ps == $past(leb_next_ps);
	endproperty
	a_leb_hold: assert property (p_leb_hold)
		else $error("blank counter stopped early");

	property p_blank_low_high;
		st_q.ctrl.blank_on_low_out_high && st_d.low_out
			|=> !st_q.fault_out && !st_q.curlim_out;
	endproperty
	a_blank_low_high: assert property (p_blank_low_high)
		else $error("inputs passed while low output high");

	property p_blank_low_low;
		st_q.ctrl.blank_on_low_out_low && !st_d.low_out
			|=> !st_q.fault_out && !st_q.curlim_out;
	endproperty
	a_blank_low_low: assert property (p_blank_low_low)
		else $error("inputs passed while low output low");

	property p_edge_fault;
		st_q.leb_run && st_q.ctrl.fault_edge_blank_enable
			##1 st_q.leb_run |-> !st_q.fault_out;
	endproperty
	a_edge_fault: assert property (p_edge_fault)
		else $error("fault passed during edge blanking");

	property p_chop_high;
		st_q.aux.chop_high_enable && !chop_src |=> !gen_high_output;
	endproperty
	a_chop_high: assert property (p_chop_high)
		else $error("high output active with chop source low");

	property p_chop_low_off;
		!st_q.aux.chop_low_enable |=> gen_low_output == $past(gen_low_in);
	endproperty
	a_chop_low_off: assert property (p_chop_low_off)
		else $error("low output altered with chopping disabled");

	property p_capture;
		st_d.curlim_out && !st_q.curlim_out && !external_period_reset_sel
			|=> st_q.cap == $past(timebase);
	endproperty
	a_capture: assert property (p_capture)
		else $error("time base not captured on limit edge");

	property p_cap_blocked;
		external_period_reset_sel |=> $stable(st_q.cap);
	endproperty
	a_cap_blocked: assert property (p_cap_blocked)
		else $error("capture changed while external reset selected");

	property p_aux_zero;
		bus_req.rd && bus_req.addr == OFF_AUX
			|=> bus_rd_data[13:12] == 2'b00 && bus_rd_data[7:6] == 2'b00;
	endproperty
	a_aux_zero: assert property (p_aux_zero)
		else $error("unimplemented auxiliary bits read nonzero");

	// ========================================================================
	// Further checks on chopping, state and edge blanking, register access and capture.
	property p_chop_low;
		st_q.aux.chop_low_enable && !chop_src
			|=> !gen_low_output;
	endproperty
	a_chop_low: assert property (p_chop_low)
		else $error("low output active with chop source low");

	property p_chop_high_off;
		!st_q.aux.chop_high_enable
			|=> gen_high_output == $past(gen_high_in);
	endproperty
	a_chop_high_off: assert property (p_chop_high_off)
		else $error("high output altered with chopping disabled");

	property p_blank_high_high;
		st_q.ctrl.blank_on_high_out_high && st_d.high_out
			|=> !st_q.fault_out && !st_q.curlim_out;
	endproperty
	a_blank_high_high: assert property (p_blank_high_high)
		else $error("inputs passed while high output high");

	property p_blank_high_low;
		st_q.ctrl.blank_on_high_out_low && !st_d.high_out
			|=> !st_q.fault_out && !st_q.curlim_out;
	endproperty
	a_blank_high_low: assert property (p_blank_high_low)
		else $error("inputs passed while high output low");

	property p_blank_src_high;
		st_q.ctrl.blank_when_source_high && blank_src
			|=> !st_q.fault_out && !st_q.curlim_out;
	endproperty
	a_blank_src_high: assert property (p_blank_src_high)
		else $error("inputs passed while blank source high");

	property p_blank_src_low;
		st_q.ctrl.blank_when_source_low && !blank_src &&
			st_q.aux.state_blank_source != SRC_NONE
			|=> !st_q.fault_out && !st_q.curlim_out;
	endproperty
	a_blank_src_low: assert property (p_blank_src_low)
		else $error("inputs passed while blank source low");

	// Reserved codes must never pick up a generator.
	property p_blank_rsvd;
		st_q.aux.state_blank_source > 4'h5 |-> !blank_src;
	endproperty
	a_blank_rsvd: assert property (p_blank_rsvd)
		else $error("reserved blank source selected a generator");

	property p_chop_rsvd;
		st_q.aux.chop_source > 4'h5 |-> !chop_src;
	endproperty
	a_chop_rsvd: assert property (p_chop_rsvd)
		else $error("reserved chop source selected a signal");

	property p_edge_curlim;
		st_q.leb_run && st_q.ctrl.curlim_edge_blank_enable
			##1 st_q.leb_run |-> !st_q.curlim_out;
	endproperty
	a_edge_curlim: assert property (p_edge_curlim)
		else $error("limit passed during edge blanking");

	property p_dly_write;
		bus_req.wr && bus_req.addr == OFF_DLY
			|=> st_q.dly == $past(bus_req.wdata[DLY_MSB:DLY_LSB]);
	endproperty
	a_dly_write: assert property (p_dly_write)
		else $error("delay write not stored");

	property p_rd_idle;
		!bus_req.rd |=> bus_rd_data == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data present without a read");

	property p_cap_low_zero;
		bus_req.rd && bus_req.addr == OFF_CAP
			|=> bus_rd_data[2:0] == 3'h0;
	endproperty
	a_cap_low_zero: assert property (p_cap_low_zero)
		else $error("unimplemented capture bits read nonzero");

	// Without a blanked limit edge the captured value must hold.
	property p_cap_hold;
		!(st_d.curlim_out && !st_q.curlim_out) |=> $stable(st_q.cap);
	endproperty
	a_cap_hold: assert property (p_cap_hold)
		else $error("capture changed without a limit edge");

endmodule

// ===== testbench/pbc_stage_model.sv
// Far-side model: the primary time base counter and the chop clock.
// Assumes the bench's clock and its active-low asynchronous reset.
`timescale 1ns/1ps

module pbc_stage_model (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Far-side signals
	output      logic [12:0] timebase,
	output      logic        chop_clock
);
	// ========================================================================
	// Counters
	logic [1:0] div_q;

	// An odd divide keeps the chop clock off the bench's own cadence.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			timebase   <= 13'h0000;
			div_q      <= 2'h0;
			chop_clock <= 1'b0;
		end else begin
			timebase <= timebase + 13'h0001;
			div_q    <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
			if (div_q == 2'h2) begin
				chop_clock <= ~chop_clock;
			end
		end
	end
endmodule

// ===== testbench/pbc_blank_chop_tb.sv
// Self-checking bench for pbc_blank_chop and the far-side model.
// Assumes a 100 MHz clock and the register map of the package.
`timescale 1ns/1ps

module pbc_blank_chop_tb;
	import pbc_pkg::*;

	// ========================================================================
	// Signals
	logic         clock, rst_n, gh, gl, xps, flt, cl, e;
	logic         chop_clk, ho, lo, fb, cb, fpd, fdd;
	logic  [4:0]  peer;
	logic  [12:0] tb_val, rise_tb;
	logic  [15:0] rdat, v, cap_e;
	pbc_bus_req_t req;
	int           n_fail, checks_done;
	logic  [3:0]  offs [5] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8};
	logic  [15:0] msk  [5] = '{16'hfc3f, 16'h0ff8, 16'hcf3f, 16'h0, 16'h0};
	int           dl   [4] = '{0, 2, 511, 5};

	pbc_blank_chop u_dut (
		.clock                     (clock),
		.rst_n                     (rst_n),
		.bus_req                   (req),
		.bus_rd_data               (rdat),
		.gen_high_in               (gh),
		.gen_low_in                (gl),
		.peer_high                 (peer),
		.chop_clock                (chop_clk),
		.timebase                  (tb_val),
		.external_period_reset_sel (xps),
		.fault_in                  (flt),
		.curlim_in                 (cl),
		.gen_high_output           (ho),
		.gen_low_output            (lo),
		.fault_blanked             (fb),
		.curlim_blanked            (cb),
		.fine_period_disable       (fpd),
		.fine_duty_disable         (fdd)
	);

	pbc_stage_model u_stage (
		.clock      (clock),
		.rst_n      (rst_n),
		.timebase   (tb_val),
		.chop_clock (chop_clk)
	);

	// ========================================================================
	// Tasks
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		req.wr <= 1'b0;
	endtask

	task automatic rchk(input logic [3:0] a, input logic [15:0] ex);
		@(posedge clock);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clock);
		req.rd <= 1'b0;
		@(negedge clock);
		chk("register", rdat, ex);
	endtask

	// Makes one edge on a generator line and counts blanked cycles.
	task automatic erun(input logic low, rise, input int en, ef);
		int   nc;
		int   nf;
		logic pc;
		nc = 0;
		nf = 0;
		pc = 1'b1;
		@(posedge clock);
		if (low) gl <= ~rise; else gh <= ~rise;
		repeat (4) @(posedge clock);
		if (low) gl <= rise; else gh <= rise;
		for (int i = 0; i < en + 4; i++) begin
			@(negedge clock);
			if (cb === 1'b0) nc++;
			if (fb === 1'b0) nf++;
			if (pc === 1'b0 && cb === 1'b1) rise_tb = tb_val;
			pc = cb;
		end
		chk("limit blank cycles", nc[15:0], en[15:0]);
		chk("fault blank cycles", nf[15:0], ef[15:0]);
	endtask

	task automatic wrap_up();
		if (n_fail == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ========================================================================
	// Clock, watchdog and tests
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// The longest blank window is about 430 cycles; the whole run is under a thousand.
	initial begin
		#200000;
		n_fail++;
		wrap_up();
	end

	initial begin
		{gh, gl, xps, flt, cl} = 5'h00;
		peer = 5'h00;
		req = '0;
		n_fail = 0;
		checks_done = 0;
		rst_n = 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		foreach (offs[i]) rchk(offs[i], 16'h0000);
		foreach (offs[i]) wr(offs[i], 16'hffff);
		foreach (offs[i]) rchk(offs[i], msk[i]);
		chk("fine disables", {fpd, fdd}, 2'b11);
		wr(OFF_CTRL, 16'h0000);
		wr(OFF_DLY, 16'h0000);
		@(posedge clock);
		gh <= 1'b1;
		gl <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			wr(OFF_AUX, (c < 7) ? {10'h0, c[3:0], 2'b11} : 16'h0000);
			repeat (3) @(posedge clock);
			for (int i = 0; i < 12; i++) begin
				@(negedge clock);
				if (i > 0) chk("chop", {ho, lo}, {2{e}});
				e = (c == 7) ? 1'b1 : (c == 0) ? chop_clk :
					(c < 6) ? peer[c - 1] : 1'b0;
				@(posedge clock);
				peer <= peer + 5'h0b;
			end
		end
		chk("fine disables", {fpd, fdd}, 2'b00);
		flt <= 1'b1;
		cl <= 1'b1;
		for (int b = 0; b < 7; b++) begin
			wr(OFF_AUX, (b == 6) ? 16'h0000 : 16'h0100);
			wr(OFF_CTRL, 16'h0001 << ((b == 6) ? 5 : b));
			for (int l = 0; l < 2; l++) begin
				@(posedge clock);
				{gh, gl, peer} <= {7{l[0]}};
				repeat (3) @(negedge clock);
				e = (b == 6) ? 1'b1 : (b[0] ? ~l[0] : l[0]);
				chk("state blank", {fb, cb}, {2{e}});
			end
		end
		wr(OFF_DLY, 16'h0018);
		for (int k = 0; k < 4; k++) begin
			wr(OFF_CTRL, (16'h8000 >> k) | 16'h0400);
			erun(k > 1, !k[0], 3, 0);
		end
		erun(1'b1, 1'b1, 0, 0);
		wr(OFF_CTRL, 16'h8c00);
		foreach (dl[i]) begin
			wr(OFF_DLY, {4'h0, dl[i][8:0], 3'h0});
			erun(1'b0, 1'b1, (dl[i] * 832 + 999) / 1000,
				(dl[i] * 832 + 999) / 1000);
		end
		cap_e = {rise_tb - 13'h0001, 3'h0};
		rchk(OFF_CAP, cap_e);
		@(posedge clock);
		xps <= 1'b1;
		erun(1'b0, 1'b1, 5, 5);
		rchk(OFF_CAP, cap_e);
		wrap_up();
	end
endmodule
